/* File: dv/scp_host.sv */
// remote host model: sends command strings, takes reply bytes at its own pace
// assumes caller enters send_str just after a rising edge of clk
`default_nettype none
module scp_host (
    input wire logic clk,
    input wire logic rx_ready,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic rx_eoi,
    output logic rsp_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        rx_eoi = 1'b0;
        rsp_ready = 1'b0;
    end
    // random stalls on reply bytes exercise the hold of each byte
    always @(posedge clk) rsp_ready <= ($urandom % 3) != 0;
    // each byte held until taken; gaps random so back to back also occurs
    task automatic send_str(input string s, input bit eoi_end);
        for (int i = 0; i < s.len(); i++) begin
            rx_data <= s[i];
            rx_valid <= 1'b1;
            rx_eoi <= eoi_end && (i == s.len() - 1);
            do @(posedge clk); while (rx_ready !== 1'b1);
            if ($urandom % 4 == 0 || i == s.len() - 1) begin
                rx_valid <= 1'b0;
                rx_eoi <= 1'b0;
                rx_data <= ~s[i]; // released line shows no stale byte
                @(posedge clk);
            end
        end
    endtask
endmodule
`default_nettype wire

/* File: dv/scp_parser_asserts.sv */
// port assertions for the ascii command parser
// assumes binding to scp_parser; one clock, resetn synchronous active low
`default_nettype none
module scp_parser_asserts #(
    parameter logic [15:0] VOLT_MAX_MV = 16'h7530,
    parameter int FIFO_DEPTH = 16,
    parameter logic [1:0] STR_FIELDS_MAX = 2'h3
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire logic rx_eoi,
    input wire logic rx_ready,
    input wire logic [7:0] rsp_data,
    input wire logic rsp_valid,
    input wire logic rsp_ready,
    input wire logic [7:0] str_data,
    input wire logic str_valid,
    input wire logic [1:0] str_field,
    input wire logic beep_en,
    input wire logic [1:0] brightness,
    input wire logic [15:0] volt_mv,
    input wire logic recall_pulse,
    input wire logic [3:0] recall_slot,
    input wire logic cmd_err
);
    // single domain, so clock and reset are given once
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    a_reply_lf_last: assert property (
        rsp_valid && rsp_ready && rsp_data == scp_pkg::CH_LF |=> !rsp_valid)
        else $error("reply continued after line feed");
    a_reply_lf_next: assert property (
        rsp_valid && rsp_ready && rsp_data != scp_pkg::CH_LF
        |=> rsp_valid && rsp_data == scp_pkg::CH_LF)
        else $error("reply byte not followed by line feed");
    a_reply_held: assert property (
        rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
        else $error("reply byte dropped before taken");
    a_bright_span: assert property (brightness != 2'h0)
        else $error("brightness out of span");
    a_slot_listed: assert property (recall_pulse |-> recall_slot <= 4'h9)
        else $error("recall slot not listed");
    a_volt_range: assert property (volt_mv <= VOLT_MAX_MV)
        else $error("voltage above range");
    a_err_keeps: assert property (
        cmd_err |-> !recall_pulse ##1 ($stable(beep_en) && $stable(brightness)
        && $stable(volt_mv))) else $error("setting changed by discarded command");
    a_err_pulse: assert property (cmd_err |=> !cmd_err)
        else $error("error flag longer than one cycle");
    a_str_field: assert property (str_valid |-> str_field <= STR_FIELDS_MAX)
        else $error("string field index too large");
endmodule
bind scp_parser scp_parser_asserts #(.VOLT_MAX_MV(VOLT_MAX_MV), .FIFO_DEPTH(FIFO_DEPTH),
    .STR_FIELDS_MAX(STR_FIELDS_MAX)) scp_parser_asserts_i (.clk(clk), .resetn(resetn),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_eoi(rx_eoi), .rx_ready(rx_ready),
    .rsp_data(rsp_data), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .str_data(str_data), .str_valid(str_valid), .str_field(str_field), .beep_en(beep_en),
    .brightness(brightness), .volt_mv(volt_mv), .recall_pulse(recall_pulse),
    .recall_slot(recall_slot), .cmd_err(cmd_err));
`default_nettype wire

/* File: dv/scp_parser_tb.sv */
// self-checking bench for the ascii command parser with a host model
// assumes 20 MHz clock; expected results noted in a queue, matched in order
`default_nettype none
module scp_parser_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] VMAX = 16'h2710; // lowered top so boundary is cheap
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] rx_data, rsp_data, str_data;
    logic rx_valid, rx_eoi, rx_ready, rsp_valid, rsp_ready, str_valid;
    logic [1:0] str_field, brightness, bright_q;
    logic beep_en, recall_pulse, cmd_err, beep_q, hit;
    logic [15:0] volt_mv, volt_q;
    logic [3:0] recall_slot;
    logic [31:0] seen;
    logic [31:0] notes [$];
    int bad_count = 0;
    int num_checks = 0;
    int cycles = 0;
    string w;
    string bad_cmd [7] = '{"DISP:BRIG 0\n", "DISP:BRIG 4\n", "BRIG 2\n", "DISP:BRIGH 2\n",
        "*RCL 10\n", "SOUR:VOLT 10.001\n", "SYST:BEEP:STAT 2\n"};
    always #25 clk = ~clk;
    scp_parser #(.VOLT_MAX_MV(VMAX)) scp_parser_i (.clk(clk), .resetn(resetn),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_eoi(rx_eoi), .rx_ready(rx_ready),
        .rsp_data(rsp_data), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
        .str_data(str_data), .str_valid(str_valid), .str_field(str_field), .beep_en(beep_en),
        .brightness(brightness), .volt_mv(volt_mv), .recall_pulse(recall_pulse),
        .recall_slot(recall_slot), .cmd_err(cmd_err));
    scp_host scp_host_i (.clk(clk), .rx_ready(rx_ready), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_eoi(rx_eoi), .rsp_ready(rsp_ready));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic note(input logic [7:0] kind, input logic [23:0] val);
        notes.push_back({kind, val});
    endtask
    task automatic send(input string s, input bit eoi_end);
        scp_host_i.send_str(s, eoi_end);
    endtask
    task automatic results();
        if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // one result per cycle at most; settings seen as changes of level
    always @(posedge clk) begin
        hit = resetn === 1'b1;
        if (cmd_err === 1'b1) seen = {"E", 24'h0};
        else if (recall_pulse === 1'b1) seen = {"R", 20'h0, recall_slot};
        else if (rsp_valid === 1'b1 && rsp_ready === 1'b1) seen = {"P", 16'h0, rsp_data};
        else if (str_valid === 1'b1) seen = {"S", 14'h0, str_field, str_data};
        else if (beep_en !== beep_q) seen = {"U", 23'h0, beep_en};
        else if (brightness !== bright_q) seen = {"B", 22'h0, brightness};
        else if (volt_mv !== volt_q) seen = {"V", 8'h0, volt_mv};
        else hit = 1'b0;
        beep_q <= beep_en;
        bright_q <= brightness;
        volt_q <= volt_mv;
        if (hit && notes.size() == 0) check("unexpected result", 32'h0, seen);
        else if (hit) check("result", notes.pop_front(), seen);
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            results();
        end
    end
    initial begin
        void'($urandom(32'h9ed45db9));
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        if ($urandom % 2) w = "On";
        else w = "1";
        note("U", 24'h1);
        send({":SYST:BEEP:STAT ", w, "\n"}, 1'b0);
        note("P", 24'h31);
        note("P", {16'h0, scp_pkg::CH_LF});
        send("syst:beep?\n", 1'b0);
        note("U", 24'h0);
        send("SYSTem:BEEPer OFF\r\n", 1'b0);
        note("E", 24'h0);
        send("SYST:BEE 1\n", 1'b0);
        note("B", 24'h3);
        send("disp:Brig 3\n", 1'b0);
        foreach (bad_cmd[i]) begin
            note("E", 24'h0);
            send(bad_cmd[i], 1'b0);
        end
        note("P", 24'h33);
        note("P", {16'h0, scp_pkg::CH_LF});
        send("DISP:BRIG?\n", 1'b0);
        for (int d = 0; d < 10; d++) begin
            note("R", 24'(d));
            if (d == 9) send("*rcl 9", 1'b1);
            else send($sformatf("*RCL %0d\n", d), 1'b0);
        end
        note("V", 24'd1234);
        send("SOUR:VOLT 1.2345\n", 1'b0);
        note("V", {8'h0, VMAX});
        send("SOUR:VOLT MAX\n", 1'b0);
        note("V", 24'h0);
        send("sour:volt minimum\n", 1'b0);
        note("S", {16'h0, 8'h61});
        note("S", {16'h0, 8'h62});
        note("S", {14'h0, 2'h1, 8'h63});
        send("SYST:NAME ab,c\n", 1'b0);
        for (int k = 0; k < 400 && notes.size() > 0; k++) @(posedge clk);
        check("pending notes", 32'h0, 32'(notes.size()));
        results();
    end
endmodule
`default_nettype wire

/* File: include/scp_pkg.sv */
// constants, command tree and carrier types for the ascii command parser
// assumes byte-wide characters, one clock, synchronous active-low reset
`default_nettype none
package scp_pkg;
    // character codes
    localparam logic [7:0] CH_LF = 8'h0a;
    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [7:0] CH_SP = 8'h20;
    localparam logic [7:0] CH_COLON = 8'h3a;
    localparam logic [7:0] CH_QMARK = 8'h3f;
    localparam logic [7:0] CH_COMMA = 8'h2c;
    localparam logic [7:0] CH_DOT = 8'h2e;
    localparam logic [7:0] CH_0 = 8'h30;
    localparam logic [7:0] CH_9 = 8'h39;
    localparam logic [7:0] CH_LO_A = 8'h61;
    localparam logic [7:0] CH_LO_Z = 8'h7a;
    localparam logic [7:0] CASE_BIT = 8'h20;
    // buffers and tree size
    localparam int KW_CHARS = 10;
    localparam int WORD_CHARS = 8;
    localparam int NODE_COUNT = 9;
    localparam logic [3:0] ROOT = 4'h0;
    // value ranges
    localparam logic [15:0] BRIGHT_MIN = 16'h0001;
    localparam logic [15:0] BRIGHT_MAX = 16'h0003;
    localparam logic [15:0] SLOT_MIN = 16'h0000;
    localparam logic [15:0] SLOT_MAX = 16'h0009;
    localparam logic [15:0] BOOL_ONE = 16'h0001;
    localparam logic [15:0] BOOL_ZERO = 16'h0000;
    localparam logic [31:0] MILLI = 32'h0000_03e8;
    localparam logic [1:0] FRAC_DIGITS = 2'h3;

    typedef enum logic [2:0] {
        PT_NONE = 3'b000,
        PT_BOOL = 3'b001,
        PT_CINT = 3'b010,
        PT_DISC = 3'b011,
        PT_REAL = 3'b100,
        PT_STR = 3'b101
    } scp_ptype_type;

    // one keyword node; name right-justified, upper case
    typedef struct packed {
        logic [3:0] parent;
        logic [79:0] name;
        logic [3:0] long_len;
        logic [3:0] short_len;
        scp_ptype_type ptype;
        logic [3:0] dflt;
    } scp_node_type;

    typedef struct packed {
        logic eoi;
        logic [7:0] data;
    } scp_rx_type;

    localparam logic [3:0] N_BEEP_STATE = 4'h3;
    localparam logic [3:0] N_BRIGHT = 4'h5;
    localparam logic [3:0] N_RECALL = 4'h6;
    localparam logic [3:0] N_VOLT = 4'h8;

    localparam scp_node_type NODE_TAB [1:NODE_COUNT] = '{
        '{4'h0, 80'("SYSTEM"), 4'h6, 4'h4, PT_NONE, 4'h0},
        '{4'h1, 80'("BEEPER"), 4'h6, 4'h4, PT_NONE, 4'h3},
        '{4'h2, 80'("STATE"), 4'h5, 4'h4, PT_BOOL, 4'h0},
        '{4'h0, 80'("DISPLAY"), 4'h7, 4'h4, PT_NONE, 4'h0},
        '{4'h4, 80'("BRIGHTNESS"), 4'ha, 4'h4, PT_CINT, 4'h0},
        '{4'h0, 80'("*RCL"), 4'h4, 4'h4, PT_DISC, 4'h0},
        '{4'h0, 80'("SOURCE"), 4'h6, 4'h4, PT_NONE, 4'h0},
        '{4'h7, 80'("VOLTAGE"), 4'h7, 4'h4, PT_REAL, 4'h0},
        '{4'h1, 80'("NAME"), 4'h4, 4'h4, PT_STR, 4'h0}
    };
endpackage
`default_nettype wire

/* File: src/scp_parser.sv */
// byte-serial ascii command parser with its input fifo
// assumes bytes arrive from a transport block on clk; eoi marks a bus end byte
//
// How it works
// - colon separated keywords walked level by level
// - one space ends header, parameters follow
// - trailing question mark makes a query reply for boolean and consecutive integer nodes only
// - commas split successive string fields; a comma after any other parameter type is malformed
// - omitted optional keyword matches its default
// - keyword matching ignores letter case
// - only full or exact short form accepted
// - line feed ends the message
// - carriage return before line feed is discarded
// - end-or-identify byte is taken as data, then ends the message as a line feed would
// - terminator resets keyword path to root
// - every reply ends with one line feed
// - booleans take ON OFF 1 0
// - discrete parameter must be a listed value
// - real value within range, MIN MAX allowed
// - consecutive integer checked against its span
// - string parameters passed on unchanged
`default_nettype none

module scp_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic [AW:0] cnt_nxt;
    logic ready_r;
    logic push;
    logic pop;

    assign push = in_valid && ready_r;
    assign pop = out_valid && out_ready;
    assign out_valid = (cnt_r != '0);
    assign out_data = mem[rp_r];
    assign in_ready = ready_r;

    // occupancy; ready registered so it leaves the block from a flop
    always_comb begin
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            cnt_r <= '0;
            ready_r <= 1'b0;
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
            ready_r <= (cnt_nxt != (AW+1)'(DEPTH));
            if (push) begin
                wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
            end
        end
    end

    // storage has no reset; only written entries are ever read
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end
endmodule

module scp_parser #(
    parameter logic [15:0] VOLT_MAX_MV = 16'h7530,
    parameter int FIFO_DEPTH = 16,
    parameter logic [1:0] STR_FIELDS_MAX = 2'h3
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire logic rx_eoi,
    output logic rx_ready,
    output logic [7:0] rsp_data,
    output logic rsp_valid,
    input wire logic rsp_ready,
    output logic [7:0] str_data,
    output logic str_valid,
    output logic [1:0] str_field,
    output logic beep_en,
    output logic [1:0] brightness,
    output logic [15:0] volt_mv,
    output logic recall_pulse,
    output logic [3:0] recall_slot,
    output logic cmd_err
);
    typedef enum logic [2:0] {
        ST_HDR = 3'b000,
        ST_PARAM = 3'b001,
        ST_SKIP = 3'b010,
        ST_RSP = 3'b011,
        ST_RSP_LF = 3'b100
    } scp_state_type;

    scp_pkg::scp_rx_type fin;
    scp_pkg::scp_rx_type fout;
    logic f_valid;
    logic pop;
    scp_state_type st_r;
    logic [3:0] node_r;
    logic [79:0] kbuf_r;
    logic [3:0] klen_r;
    logic qry_r;
    logic cr_r;
    logic eoi_r;
    logic [63:0] wbuf_r;
    logic [3:0] wlen_r;
    logic [15:0] ival_r;
    logic [9:0] fval_r;
    logic [1:0] fdig_r;
    logic dot_r;
    logic num_r;
    logic bad_r;
    logic [1:0] pidx_r;
    logic [7:0] rsp_r;
    logic rsp_valid_r;
    logic [7:0] str_r;
    logic str_valid_r;
    logic [1:0] str_field_r;
    logic beep_r;
    logic [1:0] bright_r;
    logic [15:0] volt_r;
    logic recall_r;
    logic [3:0] slot_r;
    logic err_r;
    logic [7:0] c;
    logic [7:0] cu;
    logic lf;
    logic term;
    logic [3:0] hit;
    logic [3:0] hdr_node;
    scp_pkg::scp_ptype_type hdr_type;
    logic ok;
    logic [15:0] val;
    logic [31:0] mv;

    assign fin = '{eoi: rx_eoi, data: rx_data};

    scp_fifo #(.WIDTH($bits(scp_pkg::scp_rx_type)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .resetn(resetn),
        .in_data(fin),
        .in_valid(rx_valid),
        .in_ready(rx_ready),
        .out_data(fout),
        .out_valid(f_valid),
        .out_ready(pop)
    );

    // upper-case a letter so keywords and words compare case-free
    function automatic logic [7:0] upc(input logic [7:0] b);
        return (b >= scp_pkg::CH_LO_A && b <= scp_pkg::CH_LO_Z) ? (b & ~scp_pkg::CASE_BIT) : b;
    endfunction

    function automatic logic is_dig(input logic [7:0] b);
        return b >= scp_pkg::CH_0 && b <= scp_pkg::CH_9;
    endfunction

    // child of parent matching the buffer in full or exact short form
    function automatic logic [3:0] lookup(input logic [3:0] parent, input logic [79:0] kb,
                                          input logic [3:0] kl);
        logic [3:0] id;
        scp_pkg::scp_node_type n;
        id = scp_pkg::ROOT;
        for (int i = 1; i <= scp_pkg::NODE_COUNT; i++) begin
            n = scp_pkg::NODE_TAB[i];
            if (n.parent == parent) begin
                if ((kl == n.long_len && kb == n.name) ||
                    (kl == n.short_len &&
                     kb == (n.name >> {n.long_len - n.short_len, 3'b000}))) begin
                    id = 4'(i);
                end
            end
        end
        return id;
    endfunction

    // drain the fifo unless a reply is going out or an end byte is pending
    assign pop = f_valid && !eoi_r && (st_r != ST_RSP) && (st_r != ST_RSP_LF);
    assign c = fout.data;
    assign cu = upc(c);
    assign lf = pop && (c == scp_pkg::CH_LF);
    assign term = lf || eoi_r;

    // keyword path resolution including omitted default levels
    always_comb begin
        hit = (klen_r != 4'h0) ? lookup(node_r, kbuf_r, klen_r) : node_r;
        hdr_node = hit;
        if (hit != scp_pkg::ROOT && scp_pkg::NODE_TAB[hit].ptype == scp_pkg::PT_NONE &&
            scp_pkg::NODE_TAB[hit].dflt != scp_pkg::ROOT) begin
            hdr_node = scp_pkg::NODE_TAB[hit].dflt;
        end
        hdr_type = (hdr_node == scp_pkg::ROOT) ? scp_pkg::PT_NONE
                                               : scp_pkg::NODE_TAB[hdr_node].ptype;
    end

    // type and range check of the gathered parameter
    always_comb begin
        ok = 1'b0;
        val = ival_r;
        mv = 32'(ival_r) * scp_pkg::MILLI;
        case (fdig_r)
            2'h1: mv = mv + 32'(fval_r) * 32'h64;
            2'h2: mv = mv + 32'(fval_r) * 32'h0a;
            2'h3: mv = mv + 32'(fval_r);
            default: mv = mv;
        endcase
        case (node_r)
            scp_pkg::N_BEEP_STATE: begin
                if ((wlen_r == 4'h2 && wbuf_r == 64'("ON")) ||
                    (num_r && !dot_r && ival_r == scp_pkg::BOOL_ONE)) begin
                    ok = 1'b1;
                    val = scp_pkg::BOOL_ONE;
                end else if ((wlen_r == 4'h3 && wbuf_r == 64'("OFF")) ||
                             (num_r && !dot_r && ival_r == scp_pkg::BOOL_ZERO)) begin
                    ok = 1'b1;
                    val = scp_pkg::BOOL_ZERO;
                end
            end
            scp_pkg::N_BRIGHT: begin
                ok = num_r && !dot_r && ival_r >= scp_pkg::BRIGHT_MIN &&
                     ival_r <= scp_pkg::BRIGHT_MAX;
            end
            scp_pkg::N_RECALL: begin
                ok = num_r && !dot_r && ival_r >= scp_pkg::SLOT_MIN &&
                     ival_r <= scp_pkg::SLOT_MAX;
            end
            scp_pkg::N_VOLT: begin
                if ((wlen_r == 4'h3 && wbuf_r == 64'("MIN")) ||
                    (wlen_r == 4'h7 && wbuf_r == 64'("MINIMUM"))) begin
                    ok = 1'b1;
                    val = '0;
                end else if ((wlen_r == 4'h3 && wbuf_r == 64'("MAX")) ||
                             (wlen_r == 4'h7 && wbuf_r == 64'("MAXIMUM"))) begin
                    ok = 1'b1;
                    val = VOLT_MAX_MV;
                end else if (num_r && mv <= 32'(VOLT_MAX_MV)) begin
                    ok = 1'b1;
                    val = mv[15:0];
                end
            end
            default: ok = 1'b1;
        endcase
        if (bad_r) begin
            ok = 1'b0;
        end
    end

    // command sequencer: header, parameters, discard, reply
    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_r <= ST_HDR;
            node_r <= scp_pkg::ROOT;
            kbuf_r <= '0;
            klen_r <= '0;
            qry_r <= 1'b0;
            cr_r <= 1'b0;
            eoi_r <= 1'b0;
            pidx_r <= '0;
        end else if (st_r == ST_RSP) begin
            if (rsp_valid_r && rsp_ready) begin
                st_r <= ST_RSP_LF;
            end
        end else if (st_r == ST_RSP_LF) begin
            if (rsp_ready) begin
                st_r <= ST_HDR;
                node_r <= scp_pkg::ROOT;
            end
        end else if (term) begin
            // path back to root before the next command
            node_r <= scp_pkg::ROOT;
            kbuf_r <= '0;
            klen_r <= '0;
            qry_r <= 1'b0;
            cr_r <= 1'b0;
            eoi_r <= 1'b0;
            pidx_r <= '0;
            st_r <= ST_HDR;
            if (st_r == ST_HDR && qry_r &&
                (hdr_type == scp_pkg::PT_BOOL || hdr_type == scp_pkg::PT_CINT)) begin
                st_r <= ST_RSP;
                node_r <= hdr_node;                                 // reply needs queried node
            end
        end else if (pop) begin
            eoi_r <= fout.eoi;
            cr_r <= (c == scp_pkg::CH_CR);
            if (cr_r) begin
                st_r <= ST_SKIP;                                    // lone cr is malformed
            end else if (c == scp_pkg::CH_CR) begin
                st_r <= st_r;
            end else if (st_r == ST_HDR) begin
                if (qry_r) begin
                    st_r <= ST_SKIP;                                // nothing may follow '?'
                end else if (c == scp_pkg::CH_COLON) begin
                    if (klen_r != 4'h0) begin
                        if (hit == scp_pkg::ROOT) begin
                            st_r <= ST_SKIP;
                        end
                        node_r <= hit;
                    end
                    kbuf_r <= '0;
                    klen_r <= '0;
                end else if (c == scp_pkg::CH_SP || c == scp_pkg::CH_QMARK) begin
                    node_r <= hdr_node;
                    kbuf_r <= '0;
                    klen_r <= '0;
                    qry_r <= (c == scp_pkg::CH_QMARK);
                    if (hdr_type == scp_pkg::PT_NONE) begin
                        st_r <= ST_SKIP;
                    end else if (c == scp_pkg::CH_SP) begin
                        st_r <= ST_PARAM;
                    end
                end else if (klen_r == 4'(scp_pkg::KW_CHARS)) begin
                    st_r <= ST_SKIP;
                end else begin
                    kbuf_r <= {kbuf_r[71:0], cu};
                    klen_r <= klen_r + 1'b1;
                end
            end else if (st_r == ST_PARAM && c == scp_pkg::CH_COMMA) begin
                pidx_r <= pidx_r + 1'b1;
                if (scp_pkg::NODE_TAB[node_r].ptype != scp_pkg::PT_STR ||
                    pidx_r == STR_FIELDS_MAX) begin
                    st_r <= ST_SKIP;
                end
            end
        end
    end

    // header ending at the terminator; LF inside the header word acts as end
    // parameter token accumulators, cleared at each separator
    always_ff @(posedge clk) begin
        if (!resetn || term || (pop && c == scp_pkg::CH_COMMA) || st_r != ST_PARAM) begin
            wbuf_r <= '0;
            wlen_r <= '0;
            ival_r <= '0;
            fval_r <= '0;
            fdig_r <= '0;
            dot_r <= 1'b0;
            num_r <= 1'b0;
            bad_r <= 1'b0;
        end else if (pop && c != scp_pkg::CH_CR && c != scp_pkg::CH_SP) begin
            if (is_dig(c) && wlen_r == 4'h0) begin
                num_r <= 1'b1;
                if (!dot_r) begin
                    ival_r <= 16'(ival_r * 16'h000a + 16'(c - scp_pkg::CH_0));
                    bad_r <= bad_r || (ival_r > 16'h1999);          // overflow guard
                end else if (fdig_r != scp_pkg::FRAC_DIGITS) begin
                    fval_r <= 10'(fval_r * 10'h00a + 10'(c - scp_pkg::CH_0));
                    fdig_r <= fdig_r + 1'b1;
                end
            end else if (c == scp_pkg::CH_DOT && num_r && !dot_r) begin
                dot_r <= 1'b1;
            end else if (!num_r && wlen_r != 4'(scp_pkg::WORD_CHARS)) begin
                wbuf_r <= {wbuf_r[55:0], cu};
                wlen_r <= wlen_r + 1'b1;
            end else begin
                bad_r <= 1'b1;
            end
        end
    end

    // settings change only on a clean terminator
    always_ff @(posedge clk) begin
        if (!resetn) begin
            beep_r <= 1'b0;
            bright_r <= scp_pkg::BRIGHT_MIN[1:0];
            volt_r <= '0;
            recall_r <= 1'b0;
            slot_r <= '0;
            err_r <= 1'b0;
        end else begin
            recall_r <= 1'b0;
            err_r <= 1'b0;
            if (term && (st_r == ST_HDR || st_r == ST_PARAM || st_r == ST_SKIP)) begin
                if (st_r == ST_SKIP || (st_r == ST_PARAM && !ok)) begin
                    err_r <= 1'b1;
                end else if (st_r == ST_HDR) begin
                    err_r <= (klen_r != 4'h0 || node_r != scp_pkg::ROOT) &&
                             !(qry_r && (hdr_type == scp_pkg::PT_BOOL ||
                                         hdr_type == scp_pkg::PT_CINT));
                end else begin
                    case (node_r)
                        scp_pkg::N_BEEP_STATE: beep_r <= val[0];
                        scp_pkg::N_BRIGHT: bright_r <= val[1:0];
                        scp_pkg::N_VOLT: volt_r <= val;
                        scp_pkg::N_RECALL: begin
                            recall_r <= 1'b1;
                            slot_r <= val[3:0];
                        end
                        default: err_r <= 1'b0;
                    endcase
                end
            end
        end
    end

    // string bytes forwarded as they arrive, with their field index
    always_ff @(posedge clk) begin
        if (!resetn) begin
            str_r <= '0;
            str_valid_r <= 1'b0;
            str_field_r <= '0;
        end else begin
            str_valid_r <= pop && !term && st_r == ST_PARAM && c != scp_pkg::CH_COMMA &&
                           c != scp_pkg::CH_CR &&
                           scp_pkg::NODE_TAB[node_r].ptype == scp_pkg::PT_STR;
            str_r <= c;
            str_field_r <= pidx_r;
        end
    end

    // query reply: one digit then a single line feed
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rsp_r <= '0;
            rsp_valid_r <= 1'b0;
        end else if (st_r == ST_RSP && !rsp_valid_r) begin
            rsp_r <= scp_pkg::CH_0 + ((node_r == scp_pkg::N_BRIGHT) ? 8'(bright_r) : 8'(beep_r));
            rsp_valid_r <= 1'b1;
        end else if (st_r == ST_RSP && rsp_ready) begin
            rsp_r <= scp_pkg::CH_LF;
        end else if (st_r == ST_RSP_LF && rsp_ready) begin
            rsp_valid_r <= 1'b0;
        end
    end

    assign rsp_data = rsp_r;
    assign rsp_valid = rsp_valid_r;
    assign str_data = str_r;
    assign str_valid = str_valid_r;
    assign str_field = str_field_r;
    assign beep_en = beep_r;
    assign brightness = bright_r;
    assign volt_mv = volt_r;
    assign recall_pulse = recall_r;
    assign recall_slot = slot_r;
    assign cmd_err = err_r;
endmodule

`default_nettype wire
